//--- logic/sspl_device.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module sspl_device (
    input wire logic clk, // Clock.
    input wire logic rstn, // Async reset, active low.
    input wire logic boot_top, // High for top boot configuration.
    input wire logic [sspl_pkg::DATA_W-1:0] array_rdata, // Normal array data.
    input wire logic [sspl_pkg::DATA_W-1:0] otp_rdata, // Secure sector data.
    input wire logic small_bank_sel, // Current address is in small bank.
    output logic otp_mapped, // Overlay active.
    output logic pw_mode_locked, // Password mode bit programmed.
    output logic ps_mode_locked, // Persistent mode bit programmed.
    output logic [7:0] vlock_bits, // Volatile sector lock bits.
    sspl_if.dev bus // Flash bus.
);
    sspl_pkg::sspl_state_e state_r;
    logic [63:0] pw_r;
    logic otp_r, pwm_r, psm_r, susp_r, lockop_r, timeout_r;
    logic [7:0] vlock_r;
    logic [$clog2(sspl_pkg::OP_CYCLES+1)-1:0] cnt_r;
    logic [sspl_pkg::DATA_W-1:0] rdata_r;
    logic [7:0] cmd;
    logic [1:0] sel;
    logic in_otp, in_inv, ul1, ul2;
    logic [63:0] pw_nxt;
    logic [63:0] mask;

    assign cmd = bus.wdata[7:0];
    assign sel = bus.word_mode ? {1'b0, bus.addr[0]} : bus.addr[1:0];
    assign ul1 = bus.addr[11:0] == sspl_pkg::UNLOCK1_ADDR && cmd == sspl_pkg::UNLOCK1_DATA;
    assign ul2 = bus.addr[11:0] == sspl_pkg::UNLOCK2_ADDR && cmd == sspl_pkg::UNLOCK2_DATA;
    assign in_otp = boot_top ? bus.addr <= sspl_pkg::OTP_TOP_HI
                             : bus.addr >= sspl_pkg::OTP_BOT_LO;
    assign in_inv = boot_top ? bus.addr <= sspl_pkg::INV_TOP_HI && !in_otp
                             : bus.addr >= sspl_pkg::INV_BOT_LO && !in_otp;

    always_comb begin
        mask = bus.word_mode ? (64'h00000000ffffffff << {sel[0], 5'd0})
                             : (64'h000000000000ffff << {sel, 4'd0});
        pw_nxt = bus.word_mode ? ({2{bus.wdata}} & mask) | ~mask
                               : ({4{bus.wdata[15:0]}} & mask) | ~mask;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= sspl_pkg::SSPL_READ;
            otp_r <= 1'b0;
            pw_r <= sspl_pkg::PW_RESET;
            pwm_r <= 1'b0;
            psm_r <= 1'b0;
            susp_r <= 1'b0;
            vlock_r <= 8'h00;
            cnt_r <= '0;
            lockop_r <= 1'b0;
            timeout_r <= 1'b0;
        end else begin
            if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
            end
            if (bus.we) begin
                if (cmd == sspl_pkg::CMD_RESET && state_r != sspl_pkg::SSPL_UL2) begin
                    state_r <= sspl_pkg::SSPL_READ;
                    lockop_r <= 1'b0;
                    timeout_r <= 1'b0;
                end else begin
                    unique case (state_r)
                        sspl_pkg::SSPL_READ, sspl_pkg::SSPL_PW_VERIFY,
                        sspl_pkg::SSPL_VLOCK_VERIFY: begin
                            if (ul1) begin
                                state_r <= sspl_pkg::SSPL_UL1;
                            end else if (cmd == sspl_pkg::CMD_SUSPEND && !otp_r) begin
                                susp_r <= 1'b1;
                            end else if (cmd == sspl_pkg::CMD_RESUME && !otp_r) begin
                                susp_r <= 1'b0;
                            end
                        end
                        sspl_pkg::SSPL_UL1: begin
                            state_r <= ul2 ? sspl_pkg::SSPL_UL2 : sspl_pkg::SSPL_READ;
                        end
                        sspl_pkg::SSPL_UL2: begin
                            state_r <= sspl_pkg::SSPL_READ;
                            unique case (cmd)
                                sspl_pkg::CMD_OTP_ENTRY: otp_r <= 1'b1;
                                sspl_pkg::CMD_SEC_RESET: otp_r <= 1'b0;
                                sspl_pkg::CMD_PW_PROG: state_r <= sspl_pkg::SSPL_PW_PROG_ADDR;
                                sspl_pkg::CMD_PW_VERIFY: state_r <= sspl_pkg::SSPL_PW_VERIFY;
                                sspl_pkg::CMD_VLOCK_WRITE: state_r <= sspl_pkg::SSPL_VLOCK_ADDR;
                                sspl_pkg::CMD_VLOCK_VERIFY: state_r <= sspl_pkg::SSPL_VLOCK_VERIFY;
                                sspl_pkg::CMD_PW_MODE_PROG: begin
                                    if (!psm_r) begin
                                        pwm_r <= 1'b1;
                                    end
                                    timeout_r <= psm_r;
                                    cnt_r <= sspl_pkg::OP_CYCLES[$bits(cnt_r)-1:0];
                                    state_r <= sspl_pkg::SSPL_STATUS;
                                end
                                sspl_pkg::CMD_PS_MODE_PROG: begin
                                    if (!pwm_r) begin
                                        psm_r <= 1'b1;
                                    end
                                    timeout_r <= pwm_r;
                                    cnt_r <= sspl_pkg::OP_CYCLES[$bits(cnt_r)-1:0];
                                    state_r <= sspl_pkg::SSPL_STATUS;
                                end
                                sspl_pkg::CMD_LOCK_OP: begin
                                    lockop_r <= 1'b1;
                                    cnt_r <= sspl_pkg::OP_CYCLES[$bits(cnt_r)-1:0];
                                end
                                default: ;
                            endcase
                        end
                        sspl_pkg::SSPL_PW_PROG_ADDR: begin
                            if (!pwm_r) begin
                                pw_r <= pw_r & pw_nxt;
                            end
                            timeout_r <= pwm_r || ((~pw_r & pw_nxt) != 64'h0);
                            cnt_r <= sspl_pkg::OP_CYCLES[$bits(cnt_r)-1:0];
                            state_r <= sspl_pkg::SSPL_STATUS;
                        end
                        sspl_pkg::SSPL_VLOCK_ADDR: begin
                            if (!(otp_r && in_otp | in_inv)) begin
                                vlock_r[bus.addr[18:16]] <= cmd[0];
                            end
                            state_r <= sspl_pkg::SSPL_READ;
                        end
                        default: ;
                    endcase
                end
            end else if (lockop_r && cnt_r == '0) begin
                lockop_r <= 1'b0;
            end
        end
    end

    // Read data registered one cycle after the read strobe.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else if (bus.re) begin
            if (state_r == sspl_pkg::SSPL_STATUS) begin
                rdata_r <= cnt_r != '0 ? sspl_pkg::STATUS_BUSY
                         : timeout_r ? sspl_pkg::STATUS_TIMEOUT
                         : sspl_pkg::STATUS_DONE;
            end else if (state_r == sspl_pkg::SSPL_PW_VERIFY) begin
                rdata_r <= pwm_r ? sspl_pkg::ALL_ONES
                         : bus.word_mode ? pw_r[{sel[0], 5'd0} +: 32]
                         : {16'h0000, pw_r[{sel, 4'd0} +: 16]};
            end else if (lockop_r && small_bank_sel) begin
                rdata_r <= sspl_pkg::STATUS_BUSY;
            end else if (state_r == sspl_pkg::SSPL_VLOCK_VERIFY) begin
                rdata_r <= otp_r ? sspl_pkg::INVALID_DATA
                         : {31'h0, vlock_r[bus.addr[18:16]]};
            end else if (otp_r && in_otp) begin
                rdata_r <= otp_rdata;
            end else if (otp_r && in_inv) begin
                rdata_r <= sspl_pkg::INVALID_DATA;
            end else begin
                rdata_r <= array_rdata;
            end
        end
    end

    assign bus.rdata = rdata_r;
    assign bus.busy = (cnt_r != '0);
    assign otp_mapped = otp_r;
    assign pw_mode_locked = pwm_r;
    assign ps_mode_locked = psm_r;
    assign vlock_bits = vlock_r;
endmodule : sspl_device

//--- logic/sspl_pkg.sv
// Functional notes
// - Entry maps OTP sector over outer small sector.
// - OTP window location depends on boot configuration.
// - Rest of overlaid sector reads invalid.
// - Listed commands stay accepted while overlay active.
// - Bypass, query, accelerated, suspend, resume ignored.
// - Entry accepted while program/erase suspended.
// - Suspend commands ignored while overlay active.
// - Host resumes suspended work after leaving overlay.
// - Lock operations in progress return status.
// - Volatile lock write skips overlaid sector.
// - Volatile lock verify under overlay invalid.
// - Host writes four x16 or two x32 portions.
// - Each portion: unlock, 38h, address/data.
// - Password programming returns status until reset.
// - Password program only clears bits; else timeout.
// - Password starts all ones; any value valid.
// - Verify returns password unless mode bit set.
// - Verify ignores bank; low bits pick portion.
// - Password mode bit permanent, blocks updates; code clears it on rstn.
// - Password mode bit program repeatable until reset.
// - Persistent mode bit inhibits password mode bit.
// - Persistent mode bit program repeatable until reset.
package sspl_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;
    localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
    localparam logic [11:0] UNLOCK2_ADDR = 12'h2aa;
    localparam logic [7:0] UNLOCK1_DATA = 8'haa;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_OTP_ENTRY = 8'h88;
    localparam logic [7:0] CMD_SEC_RESET = 8'h90;
    localparam logic [7:0] CMD_PW_PROG = 8'h38;
    localparam logic [7:0] CMD_PW_VERIFY = 8'hc8;
    localparam logic [7:0] CMD_PW_MODE_PROG = 8'h28;
    localparam logic [7:0] CMD_PS_MODE_PROG = 8'h48;
    // Kept apart from the mode bit codes so the command decode has no overlapping items.
    localparam logic [7:0] CMD_VLOCK_WRITE = 8'he0;
    localparam logic [7:0] CMD_VLOCK_VERIFY = 8'h58;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_ACCEL = 8'ha0 ^ 8'h0f;
    localparam logic [7:0] CMD_LOCK_OP = 8'h60;
    localparam logic [ADDR_W-1:0] OTP_TOP_LO = 19'h00000;
    localparam logic [ADDR_W-1:0] OTP_TOP_HI = 19'h0003f;
    localparam logic [ADDR_W-1:0] INV_TOP_HI = 19'h007ff;
    localparam logic [ADDR_W-1:0] OTP_BOT_LO = 19'h7ffc0;
    localparam logic [ADDR_W-1:0] INV_BOT_LO = 19'h7f800;
    localparam logic [ADDR_W-1:0] OTP_BOT_HI = 19'h7ffff;
    localparam logic [63:0] PW_RESET = 64'hffffffffffffffff;
    localparam logic [DATA_W-1:0] ALL_ONES = 32'hffffffff;
    localparam logic [DATA_W-1:0] INVALID_DATA = 32'hdeaddead;
    localparam logic [DATA_W-1:0] STATUS_BUSY = 32'h00000040;
    localparam logic [DATA_W-1:0] STATUS_DONE = 32'h00000080;
    localparam logic [DATA_W-1:0] STATUS_TIMEOUT = 32'h00000020;
    localparam int OP_CYCLES = 4;
    typedef enum logic [2:0] {SSPL_READ, SSPL_UL1, SSPL_UL2, SSPL_PW_PROG_ADDR,
        SSPL_STATUS, SSPL_PW_VERIFY, SSPL_VLOCK_ADDR, SSPL_VLOCK_VERIFY} sspl_state_e;
endpackage : sspl_pkg

//--- logic/sspl_if.sv
`timescale 1ns/1ps
interface sspl_if;
    logic [sspl_pkg::ADDR_W-1:0] addr;
    logic [sspl_pkg::DATA_W-1:0] wdata;
    logic we;
    logic re;
    logic word_mode;
    logic [sspl_pkg::DATA_W-1:0] rdata;
    logic busy;
    modport dev (input addr, wdata, we, re, word_mode, output rdata, busy);
    modport host (output addr, wdata, we, re, word_mode, input rdata, busy);
endinterface : sspl_if

//--- logic/sspl_host.sv
`timescale 1ns/1ps
module sspl_host (
    input wire logic clk, // Clock.
    input wire logic rstn, // Async reset, active low.
    input wire logic cmd_valid, // One-cycle order: write or read.
    input wire logic cmd_write, // High for write.
    input wire logic [sspl_pkg::ADDR_W-1:0] cmd_addr, // Order address.
    input wire logic [sspl_pkg::DATA_W-1:0] cmd_wdata, // Order data.
    input wire logic cfg_word, // Bus width select, high for x32.
    output logic [sspl_pkg::DATA_W-1:0] rsp_data, // Read answer.
    output logic rsp_valid, // Answer pulse.
    sspl_if.host bus // Flash bus.
);
    logic re_r, we_r, pend_r, word_r;
    logic [sspl_pkg::ADDR_W-1:0] addr_r;
    logic [sspl_pkg::DATA_W-1:0] wdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Sequencing of unlock cycles and portions is software's duty.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            re_r <= 1'b0;
            we_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            word_r <= 1'b0;
        end else begin
            re_r <= cmd_valid && !cmd_write;
            we_r <= cmd_valid && cmd_write;
            word_r <= cfg_word;
            if (cmd_valid) begin
                addr_r <= cmd_addr;
                wdata_r <= cmd_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_r <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end else begin
            pend_r <= re_r;
            rsp_valid <= pend_r;
            if (pend_r) begin
                rsp_data <= bus.rdata;
            end
        end
    end

    assign bus.re = re_r;
    assign bus.we = we_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
    assign bus.word_mode = word_r;
endmodule : sspl_host

//--- testbench/sspl_assertions.sv
`timescale 1ns/1ps
module sspl_assertions (
    input wire logic clk, // Clock.
    input wire logic rstn, // Reset, active low.
    input wire logic [18:0] addr, // Bus address.
    input wire logic [31:0] wdata, // Bus write data.
    input wire logic we, // Write strobe.
    input wire logic re, // Read strobe.
    input wire logic word_mode, // High for x32.
    input wire logic [31:0] rdata, // Read data.
    input wire logic busy // Operation running.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    // A shadow decoder built from bus traffic only, so it cannot share a slip with the design.
    logic [1:0] ul_r;
    logic pwd_r, prog_r, tmo_r, ver_r, pwl_r, psl_r;
    logic [63:0] pw_r, wm, wv;
    logic [31:0] ve, vm;
    wire [7:0] c = wdata[7:0];
    always_comb begin
        wm = word_mode ? 64'hffffffff << {addr[0], 5'h0} : 64'hffff << {addr[1:0], 4'h0};
        wv = word_mode ? {2{wdata}} : {4{wdata[15:0]}};
        ve = word_mode ? pw_r[{addr[0], 5'h0} +: 32] : {16'h0, pw_r[{addr[1:0], 4'h0} +: 16]};
        vm = word_mode ? 32'hffffffff : 32'h0000ffff;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ul_r <= 2'd0;
        end else if (we) begin
            ul_r <= (addr[11:0] == 12'h555 && c == 8'haa) ? 2'd1 :
                (ul_r == 2'd1 && addr[11:0] == 12'h2aa && c == 8'h55) ? 2'd2 : 2'd0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {pwd_r, prog_r, tmo_r, ver_r, pwl_r, psl_r} <= 6'h0;
            pw_r <= 64'hffffffffffffffff;
        end else if (we && pwd_r) begin
            pwd_r <= 1'b0;
            prog_r <= 1'b1;
            tmo_r <= |(wv & ~pw_r & wm);
            pw_r <= pw_r & (wv | ~wm);
        end else if (we && c == 8'hf0) begin
            prog_r <= 1'b0;
            ver_r <= 1'b0;
        end else if (we && ul_r == 2'd2) begin
            pwd_r <= c == 8'h38 && !pwl_r;
            ver_r <= c == 8'hc8;
            pwl_r <= pwl_r | (c == 8'h28 && !psl_r);
            psl_r <= psl_r | (c == 8'h48 && !pwl_r);
        end
    end
    ////////////////////////////////////////
    sequence s_done;
        ##[1:16] !busy;
    endsequence
    chk_strobe_excl: assert property (!(we && re)) else $error("strobes together");
    chk_status_busy: assert property (prog_r && re && busy |=> rdata == 32'h40)
        else $error("busy status wrong");
    chk_status_end: assert property (prog_r && re && !busy |=>
        rdata == (tmo_r ? 32'h20 : 32'h80)) else $error("end status wrong");
    chk_verify_data: assert property (ver_r && re && !pwl_r |=>
        (rdata & $past(vm)) == $past(ve)) else $error("verify data wrong");
    chk_verify_lock: assert property (ver_r && re && pwl_r |=> rdata == 32'hffffffff)
        else $error("locked verify wrong");
    chk_rdata_hold: assert property (!re |=> $stable(rdata)) else $error("rdata moved");
    chk_busy_bound: assert property ($rose(busy) |-> s_done) else $error("busy stuck");
    chk_busy_cause: assert property ($rose(busy) |-> $past(we) || $past(we, 2))
        else $error("busy without write");
endmodule : sspl_assertions

//--- testbench/secure_sector_password_lock_tb.sv
`timescale 1ns/1ps
module secure_sector_password_lock_tb;
    logic clk, rstn, cv, cw, cfg_word, boot_top, rsp_valid, om, pwl, psl;
    logic [18:0] ca;
    logic [31:0] cd, rsp_data, arr, otp, got, rnd;
    logic [7:0] vl;
    logic [63:0] pw;
    int errors, num_checks, cyc, i;
    sspl_if bus_if();
    sspl_device u_sspl_device (.clk(clk), .rstn(rstn), .boot_top(boot_top), .array_rdata(arr),
        .otp_rdata(otp), .small_bank_sel(1'b1), .otp_mapped(om), .pw_mode_locked(pwl),
        .ps_mode_locked(psl), .vlock_bits(vl), .bus(bus_if.dev));
    sspl_host u_sspl_host (.clk(clk), .rstn(rstn), .cmd_valid(cv), .cmd_write(cw), .cmd_addr(ca),
        .cmd_wdata(cd), .cfg_word(cfg_word), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .bus(bus_if.host));
    sspl_assertions u_chk (.clk(clk), .rstn(rstn), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .we(bus_if.we), .re(bus_if.re), .word_mode(bus_if.word_mode), .rdata(bus_if.rdata),
        .busy(bus_if.busy));
    ////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [18:0] a, input logic [31:0] d);
        cv <= 1'b1;
        cw <= 1'b1;
        ca <= a;
        cd <= d;
        @(posedge clk);
        cv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : wr
    // Answers are sampled at the falling edge so the registered pulse has settled.
    task automatic rd(input logic [18:0] a);
        cv <= 1'b1;
        cw <= 1'b0;
        ca <= a;
        @(posedge clk);
        cv <= 1'b0;
        repeat (8) begin
            @(negedge clk);
            if (rsp_valid === 1'b1) break;
        end
        got = rsp_data;
        @(posedge clk);
    endtask : rd
    task automatic cmd(input logic [7:0] c);
        wr(19'h555, 32'haa);
        wr(19'h2aa, 32'h55);
        wr(19'h555, {24'h0, c});
    endtask : cmd
    task automatic poll(input logic [18:0] a);
        repeat (10) begin
            rd(a);
            if (got !== 32'h40) break;
        end
    endtask : poll
    task automatic rtr();
        wr(19'h0, 32'hf0);
    endtask : rtr
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        {rstn, cv, cw, ca, cd} = '0;
        {cfg_word, boot_top} = 2'b11;
        {errors, num_checks, cyc} = '0;
        pw = 64'hffffffffffffffff;
        rnd = $urandom(32'h8bba);
        arr = $urandom;
        otp = $urandom;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        cmd(8'hc8);
        for (i = 0; i < 2; i++) begin
            rd(19'(i));
            chk("fresh half", pw[i*32 +: 32], got);
        end
        rtr();
        rnd = $urandom;
        pw[63:32] = pw[63:32] & rnd;
        cmd(8'h38);
        wr(19'h1, rnd);
        poll(19'h40000);
        chk("prog status", 32'h80, got);
        rtr();
        cmd(8'h38);
        wr(19'h1, 32'hffffffff);
        poll(19'h0);
        chk("ones over zeros", (&rnd) ? 32'h80 : 32'h20, got);
        rtr();
        cfg_word <= 1'b0;
        rnd = $urandom;
        pw[47:32] = pw[47:32] & rnd[15:0];
        cmd(8'h38);
        wr(19'h2, {16'h0, rnd[15:0]});
        poll(19'h0);
        rtr();
        cmd(8'hc8);
        for (i = 0; i < 4; i++) begin
            rd(19'(i));
            chk("quarter", {16'h0, pw[i*16 +: 16]}, {16'h0, got[15:0]});
        end
        rtr();
        cfg_word <= 1'b1;
        cmd(8'hb0);
        cmd(8'h88);
        chk("mapped", 32'h1, 32'(om));
        rd(19'h00010);
        chk("otp top", otp, got);
        rd(19'h00400);
        chk("invalid top", 32'hdeaddead, got);
        cmd(8'h30);
        cmd(8'h98);
        boot_top <= 1'b0;
        rd(19'h7ffc0);
        chk("otp bottom", otp, got);
        rd(19'h7f800);
        chk("invalid bottom", 32'hdeaddead, got);
        cmd(8'h90);
        rd(19'h7ffc0);
        chk("array back", arr, got);
        rtr();
        cmd(8'h28);
        poll(19'h0);
        rtr();
        cmd(8'h48);
        poll(19'h0);
        rtr();
        chk("pw lock", 32'h1, 32'(pwl));
        chk("ps blocked", 32'h0, 32'(psl));
        cmd(8'hc8);
        rd(19'h0);
        chk("locked verify", 32'hffffffff, got);
        rtr();
        cmd(8'h88);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("unmapped", 32'h0, 32'(om));
        cmd(8'h48);
        poll(19'h0);
        rtr();
        cmd(8'h28);
        poll(19'h0);
        rtr();
        chk("ps lock", 32'h1, 32'(psl));
        chk("pw blocked", 32'h0, 32'(pwl));
        finish_test();
    end
endmodule : secure_sector_password_lock_tb
